// *** core/fagg_top.sv ***
// Fault aggregator: collects error reports, masks them, keeps a sticky
// master flag, a first-fault code, a captured program count and an irq.
// Assumes error inputs are synchronous to ref_clk and sampled each cycle.
`timescale 1ns/1ps
`include "fagg_defines.svh"

module fagg_top
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Error sources
  input  wire logic        soft_fault,
  input  wire logic        loop_fault,
  input  wire logic        stack_fault,
  input  wire logic        watchdog_fault,
  input  wire logic [3:0]  data_mem1_fault,
  input  wire logic [3:0]  data_mem0_fault,
  input  wire logic        program_mem1_fault,
  input  wire logic        program_mem0_fault,
  input  wire logic        rate_converter1_fault,
  input  wire logic        rate_converter0_fault,
  // Program count of the instruction in the execute stage
  input  wire logic [15:0] exec_pc,
  // Status outputs
  output logic             fault_flag,
  output logic             irq
);

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  wire logic wr_clear  = reg_wr && (reg_addr == `FAGG_ADDR_CLEAR);
  wire logic wr_parity = reg_wr && (reg_addr == `FAGG_ADDR_PARITY);
  wire logic wr_soft   = reg_wr && (reg_addr == `FAGG_ADDR_SOFT_MASK);
  wire logic wr_wd     = reg_wr && (reg_addr == `FAGG_ADDR_WD_MASK);
  wire logic wr_stack  = reg_wr && (reg_addr == `FAGG_ADDR_STACK_MASK);
  wire logic wr_loop   = reg_wr && (reg_addr == `FAGG_ADDR_LOOP_MASK);
  wire logic wr_istat  = reg_wr && (reg_addr == `FAGG_ADDR_IRQ_STAT);
  wire logic wr_imask  = reg_wr && (reg_addr == `FAGG_ADDR_IRQ_MASK);
  wire logic wr_exec   = reg_wr && (reg_addr == `FAGG_ADDR_EXEC_CNT);

  // ****************************************************************
  // Mask registers
  // ****************************************************************
  fagg_pkg::fagg_parity_t parity_mask;
  logic                   soft_mask;
  logic                   watchdog_fault_ignore_reg;
  logic                   stack_fault_mask;
  logic                   loop_fault_mask;
  fagg_pkg::fagg_irq_t    irq_mask;

  fagg_mask_reg #(
    .W           (`FAGG_PARITY_W),
    .RESET_VALUE (`FAGG_RST_PARITY)
  ) u_parity_mask (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_parity),
    .wr_data (reg_wdata[`FAGG_PARITY_W-1:0]),
    .q       (parity_mask)
  );

  fagg_mask_reg #(
    .W           (1),
    .RESET_VALUE (`FAGG_RST_BIT)
  ) u_soft_mask (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_soft),
    .wr_data (reg_wdata[0]),
    .q       (soft_mask)
  );

  fagg_mask_reg #(
    .W           (1),
    .RESET_VALUE (`FAGG_RST_BIT)
  ) u_wd_mask (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_wd),
    .wr_data (reg_wdata[0]),
    .q       (watchdog_fault_ignore_reg)
  );

  fagg_mask_reg #(
    .W           (1),
    .RESET_VALUE (`FAGG_RST_BIT)
  ) u_stack_mask (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_stack),
    .wr_data (reg_wdata[0]),
    .q       (stack_fault_mask)
  );

  fagg_mask_reg #(
    .W           (1),
    .RESET_VALUE (`FAGG_RST_BIT)
  ) u_loop_mask (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_loop),
    .wr_data (reg_wdata[0]),
    .q       (loop_fault_mask)
  );

  fagg_mask_reg #(
    .W           (`FAGG_IRQ_W),
    .RESET_VALUE (`FAGG_RST_IRQ_MASK)
  ) u_irq_mask (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (wr_imask),
    .wr_data (reg_wdata[`FAGG_IRQ_W-1:0]),
    .q       (irq_mask)
  );

  // ****************************************************************
  // Error gathering and masking
  // ****************************************************************
  fagg_pkg::fagg_word_t err_vec;
  fagg_pkg::fagg_word_t mask_vec;

  assign err_vec[`FAGG_CODE_SOFT]  = soft_fault;
  assign err_vec[`FAGG_CODE_LOOP]  = loop_fault;
  assign err_vec[`FAGG_CODE_STACK] = stack_fault;
  assign err_vec[`FAGG_CODE_WD]    = watchdog_fault;
  assign err_vec[`FAGG_CODE_DM1_LO+3:`FAGG_CODE_DM1_LO] = data_mem1_fault;
  assign err_vec[`FAGG_CODE_DM0_LO+3:`FAGG_CODE_DM0_LO] = data_mem0_fault;
  assign err_vec[`FAGG_CODE_PM1]   = program_mem1_fault;
  assign err_vec[`FAGG_CODE_PM0]   = program_mem0_fault;
  assign err_vec[`FAGG_CODE_RC1]   = rate_converter1_fault;
  assign err_vec[`FAGG_CODE_RC0]   = rate_converter0_fault;

  assign mask_vec[`FAGG_CODE_STACK] = stack_fault_mask;
  assign mask_vec[`FAGG_CODE_LOOP]  = loop_fault_mask;
  assign mask_vec[`FAGG_CODE_SOFT]  = soft_mask;
  assign mask_vec[`FAGG_CODE_WD]    = watchdog_fault_ignore_reg;
  assign mask_vec[`FAGG_PARITY_W-1:0] = parity_mask;

  wire fagg_pkg::fagg_word_t reported = err_vec & ~mask_vec;
  wire fagg_pkg::fagg_word_t suppressed = err_vec & mask_vec;
  wire logic any_reported   = |reported;
  wire logic any_suppressed = |suppressed;

  // ****************************************************************
  // Clear edge detection
  // ****************************************************************
  logic clear_bit_r;
  logic clear_bit_nxt;

  assign clear_bit_nxt = wr_clear ? reg_wdata[`FAGG_CLEAR_BIT] : clear_bit_r;

  // act on the zero-to-one edge only
  wire logic clear_edge = wr_clear && reg_wdata[`FAGG_CLEAR_BIT] && !clear_bit_r;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      clear_bit_r <= 1'b0;
    else
      clear_bit_r <= clear_bit_nxt;
  end

  // ****************************************************************
  // Master flag and first-fault code
  // ****************************************************************
  logic                 flag_r;
  logic                 flag_nxt;
  fagg_pkg::fagg_word_t code_r;
  fagg_pkg::fagg_word_t code_nxt;

  // Flag as seen after a pending clear; an error in the clear cycle wins
  wire logic flag_held = flag_r && !clear_edge;

  assign flag_nxt = flag_held || any_reported;

  // load only while no fault is held
  assign code_nxt = flag_held    ? code_r :
                    any_reported ? reported :
                    clear_edge   ? `FAGG_RST_WORD : code_r;

  wire logic first_fault = !flag_held && any_reported;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag_r <= 1'b0;
      code_r <= `FAGG_RST_WORD;
    end
    else
    begin
      flag_r <= flag_nxt;
      code_r <= code_nxt;
    end
  end

  // ****************************************************************
  // Execute program count capture
  // ****************************************************************
  fagg_pkg::fagg_word_t exec_cnt_r;
  fagg_pkg::fagg_word_t exec_cnt_nxt;

  // capture wins over a software write
  assign exec_cnt_nxt = soft_fault ? exec_pc   :
                        wr_exec    ? reg_wdata : exec_cnt_r;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      exec_cnt_r <= `FAGG_RST_WORD;
    else
      exec_cnt_r <= exec_cnt_nxt;
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  fagg_pkg::fagg_irq_t istat_r;
  fagg_pkg::fagg_irq_t istat_nxt;
  fagg_pkg::fagg_irq_t irq_events;
  fagg_pkg::fagg_irq_t w1c;

  assign irq_events[`FAGG_IRQ_FAULT]    = first_fault;
  assign irq_events[`FAGG_IRQ_MASKED]   = any_suppressed;
  assign irq_events[`FAGG_IRQ_SOFT_CAP] = soft_fault;

  assign w1c = wr_istat ? reg_wdata[`FAGG_IRQ_W-1:0] : '0;

  // New events win over a write-one-to-clear in the same cycle
  assign istat_nxt = (istat_r & ~w1c) | irq_events;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      istat_r <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      istat_r <= istat_nxt;
      irq     <= |(istat_nxt & ~irq_mask);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  fagg_pkg::fagg_word_t rd_mux;

  // Unmapped offsets and reserved bits read as zero
  always_comb
  begin
    rd_mux = `FAGG_RST_WORD;
    unique case (reg_addr)
      `FAGG_ADDR_CLEAR:      rd_mux[`FAGG_CLEAR_BIT] = clear_bit_r;
      `FAGG_ADDR_PARITY:     rd_mux[`FAGG_PARITY_W-1:0] = parity_mask;
      `FAGG_ADDR_SOFT_MASK:  rd_mux[0] = soft_mask;
      `FAGG_ADDR_WD_MASK:    rd_mux[0] = watchdog_fault_ignore_reg;
      `FAGG_ADDR_STACK_MASK: rd_mux[0] = stack_fault_mask;
      `FAGG_ADDR_LOOP_MASK:  rd_mux[0] = loop_fault_mask;
      `FAGG_ADDR_FLAG:       rd_mux[`FAGG_FLAG_BIT] = flag_r;
      `FAGG_ADDR_CODE:       rd_mux = code_r;
      `FAGG_ADDR_IRQ_STAT:   rd_mux[`FAGG_IRQ_W-1:0] = istat_r;
      `FAGG_ADDR_IRQ_MASK:   rd_mux[`FAGG_IRQ_W-1:0] = irq_mask;
      `FAGG_ADDR_EXEC_CNT:   rd_mux = exec_cnt_r;
      default:               rd_mux = `FAGG_RST_WORD;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= `FAGG_RST_WORD;
      fault_flag <= 1'b0;
    end
    else
    begin
      reg_rdata  <= reg_rd ? rd_mux : `FAGG_RST_WORD;
      fault_flag <= flag_nxt;
    end
  end

endmodule

// *** core/fagg_defines.svh ***
// Constants of the fault aggregator: register offsets, field positions,
// reset values and widths.
// Assumes a 16-bit register port with word addresses as printed.
`ifndef FAGG_DEFINES_SVH
`define FAGG_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FAGG_ADDR_CLEAR      16'hF421
`define FAGG_ADDR_PARITY     16'hF422
`define FAGG_ADDR_SOFT_MASK  16'hF423
`define FAGG_ADDR_WD_MASK    16'hF424
`define FAGG_ADDR_STACK_MASK 16'hF425
`define FAGG_ADDR_LOOP_MASK  16'hF426
`define FAGG_ADDR_FLAG       16'hF427
`define FAGG_ADDR_CODE       16'hF428
`define FAGG_ADDR_IRQ_STAT   16'hF429
`define FAGG_ADDR_IRQ_MASK   16'hF42A
`define FAGG_ADDR_EXEC_CNT   16'hF432

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define FAGG_PARITY_W        12
`define FAGG_IRQ_W           3
`define FAGG_RST_PARITY      12'h003
`define FAGG_RST_BIT         1'h0
`define FAGG_RST_IRQ_MASK    3'h0
`define FAGG_RST_WORD        16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define FAGG_CLEAR_BIT       0
`define FAGG_FLAG_BIT        0
`define FAGG_CODE_SOFT       15
`define FAGG_CODE_LOOP       14
`define FAGG_CODE_STACK      13
`define FAGG_CODE_WD         12
`define FAGG_CODE_DM1_LO     8
`define FAGG_CODE_DM0_LO     4
`define FAGG_CODE_PM1        3
`define FAGG_CODE_PM0        2
`define FAGG_CODE_RC1        1
`define FAGG_CODE_RC0        0
`define FAGG_IRQ_FAULT       0
`define FAGG_IRQ_MASKED      1
`define FAGG_IRQ_SOFT_CAP    2

`endif

// *** core/fagg_pkg.sv ***
// Types shared by the fault aggregator files.
// Assumes fagg_defines.svh supplies the widths.
`include "fagg_defines.svh"

package fagg_pkg;

  typedef logic [15:0]                 fagg_word_t;
  typedef logic [`FAGG_PARITY_W-1:0]   fagg_parity_t;
  typedef logic [`FAGG_IRQ_W-1:0]      fagg_irq_t;

endpackage

// *** core/fagg_mask_reg.sv ***
// One software-written configuration register with a fixed reset value.
// Assumes the caller decodes the write enable from the register port.
`timescale 1ns/1ps

module fagg_mask_reg #(
  parameter int unsigned W             = 1,
  parameter logic [W-1:0] RESET_VALUE  = '0
)
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [W-1:0]  wr_data,
  // Stored value
  output logic      [W-1:0]  q
);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= RESET_VALUE;
    end
    else if (wr_en)
    begin
      q <= wr_data;
    end
  end

endmodule

// *** testbench/fagg_checker_properties.sv ***
// Port-level checks of the fault aggregator.
// Assumes the fagg_top register map; bound to every fagg_top.
`timescale 1ns/1ps

module fagg_checker
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Error sources
  input wire logic        soft_fault,
  input wire logic        loop_fault,
  input wire logic        stack_fault,
  input wire logic        watchdog_fault,
  input wire logic [3:0]  data_mem1_fault,
  input wire logic [3:0]  data_mem0_fault,
  input wire logic        program_mem1_fault,
  input wire logic        program_mem0_fault,
  input wire logic        rate_converter1_fault,
  input wire logic        rate_converter0_fault,
  input wire logic [15:0] exec_pc,
  // Status
  input wire logic        fault_flag,
  input wire logic        irq
);
  // ****
  // Shadow of the masks, laid out like the code register
  // ****
  logic [15:0] msk_r;
  logic [2:0]  imsk_r;
  logic        clr_r;
  wire  [15:0] err_v = {soft_fault, loop_fault, stack_fault, watchdog_fault,
                        data_mem1_fault, data_mem0_fault, program_mem1_fault,
                        program_mem0_fault, rate_converter1_fault,
                        rate_converter0_fault};
  wire         hit   = |(err_v & ~msk_r);
  wire         clr_e = reg_wr && reg_addr == 16'hF421 && reg_wdata[0] && !clr_r;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      msk_r  <= 16'h0003;
      imsk_r <= 3'h0;
      clr_r  <= 1'b0;
    end
    else if (reg_wr)
      case (reg_addr)
        16'hF421: clr_r         <= reg_wdata[0];
        16'hF422: msk_r[11:0]   <= reg_wdata[11:0];
        16'hF423: msk_r[15]     <= reg_wdata[0];
        16'hF424: msk_r[12]     <= reg_wdata[0];
        16'hF425: msk_r[13]     <= reg_wdata[0];
        16'hF426: msk_r[14]     <= reg_wdata[0];
        16'hF42A: imsk_r        <= reg_wdata[2:0];
        default:  clr_r         <= clr_r;
      endcase

  // ****
  // Assertions
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_unmasked_sets: assert property (hit |=> fault_flag)
    else $error("unmasked error did not set the flag");
  chk_masked_quiet: assert property (!fault_flag && !hit |=> !fault_flag)
    else $error("flag rose without an unmasked error");
  chk_flag_sticky: assert property (fault_flag && !clr_e |=> fault_flag)
    else $error("flag dropped without a clear edge");
  chk_clear_drops: assert property (clr_e && !hit |=> !fault_flag)
    else $error("clear edge left the flag set");
  chk_flag_read: assert property (reg_rd && reg_addr == 16'hF427
    |=> reg_rdata == {15'h0000, $past(fault_flag)}) else $error("flag reads wrong");
  chk_code_clean: assert property (reg_rd && reg_addr == 16'hF428 && !fault_flag
    |=> reg_rdata == 16'h0000) else $error("code not empty while flag clear");
  chk_stack_mask: assert property (reg_rd && reg_addr == 16'hF425
    |=> reg_rdata == {15'h0000, $past(msk_r[13])}) else $error("stack mask reads wrong");
  chk_loop_mask: assert property (reg_rd && reg_addr == 16'hF426
    |=> reg_rdata == {15'h0000, $past(msk_r[14])}) else $error("loop mask reads wrong");
  chk_parity_mask: assert property (reg_rd && reg_addr == 16'hF422
    |=> reg_rdata == {4'h0, $past(msk_r[11:0])}) else $error("parity mask reads wrong");
  chk_irq_fault: assert property ($rose(fault_flag) && !imsk_r[0] |-> irq)
    else $error("new fault raised no interrupt");

  cover property (clr_e ##1 !fault_flag);
  cover property (|(err_v & msk_r));
  cover property (irq ##1 !irq);
endmodule

bind fagg_top fagg_checker chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .soft_fault(soft_fault), .loop_fault(loop_fault), .stack_fault(stack_fault),
  .watchdog_fault(watchdog_fault), .data_mem1_fault(data_mem1_fault),
  .data_mem0_fault(data_mem0_fault), .program_mem1_fault(program_mem1_fault),
  .program_mem0_fault(program_mem0_fault), .rate_converter1_fault(rate_converter1_fault),
  .rate_converter0_fault(rate_converter0_fault), .exec_pc(exec_pc),
  .fault_flag(fault_flag), .irq(irq));

// *** testbench/fagg_src_model.sv ***
// Error sources around the aggregator: one-cycle bursts on request.
// Assumes the bench raises fire for exactly one cycle per burst.
`timescale 1ns/1ps

module fagg_src_model
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Burst request, coded like the fault code
  input  wire logic        fire,
  input  wire logic [15:0] pat,
  input  wire logic [15:0] pc,
  // Error lines
  output logic [15:0]      err_v,
  output logic [15:0]      exec_pc
);
  logic [15:0] spin_r;

  // Execute stage keeps moving, so a late capture reads a wrong count
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      spin_r <= 16'h0000;
    else
      spin_r <= spin_r + 16'h0001;

  assign err_v   = fire ? pat : 16'h0000;
  assign exec_pc = (fire && pat[15]) ? pc : spin_r;
endmodule

// *** testbench/fagg_top_bench.sv ***
// Self-checking bench of the fault aggregator.
// Assumes fagg_top and the source model; the checker is bound in.
`timescale 1ns/1ps

module fagg_top_bench;
  logic        ref_clk, rst_b, reg_wr, reg_rd, fire;
  logic [15:0] reg_addr, reg_wdata, pat, pc;
  wire  [15:0] reg_rdata, exec_pc, err_v;
  wire         fault_flag, irq;
  int          n_mismatch, checks_done;

  fagg_src_model src_u (.ref_clk(ref_clk), .rst_b(rst_b), .fire(fire), .pat(pat),
    .pc(pc), .err_v(err_v), .exec_pc(exec_pc));
  fagg_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .soft_fault(err_v[15]), .loop_fault(err_v[14]), .stack_fault(err_v[13]),
    .watchdog_fault(err_v[12]), .data_mem1_fault(err_v[11:8]),
    .data_mem0_fault(err_v[7:4]), .program_mem1_fault(err_v[3]),
    .program_mem0_fault(err_v[2]), .rate_converter1_fault(err_v[1]),
    .rate_converter0_fault(err_v[0]), .exec_pc(exec_pc), .fault_flag(fault_flag),
    .irq(irq));

  // ****
  // Access tasks
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic burst(input logic [15:0] p, input logic [15:0] v);
    @(posedge ref_clk);
    pat  <= p;
    pc   <= v;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("Mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****
  // Clock, hang limit and sequence
  // ****
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop;
  end

  initial
  begin
    {rst_b, reg_wr, reg_rd, fire} = 4'h0;
    {reg_addr, reg_wdata, pat, pc} = 64'h0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(16'hF421 + 16'(i), (i == 1) ? 16'h0003 : 16'h0000);
    rd(16'hF432, 16'h0000);
    wr(16'hF430, 16'hFFFF);
    rd(16'hF430, 16'h0000);
    wr(16'hF422, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      burst(16'h0001 << i, 16'h0000);
      rd(16'hF427, 16'h0001);
      chk({15'h0000, fault_flag}, 16'h0001);
      rd(16'hF428, 16'h0001 << i);
      wr(16'hF421, 16'h0001);
      wr(16'hF421, 16'h0000);
      rd(16'hF427, 16'h0000);
    end
    wr(16'hF422, 16'hFFFF);
    for (int i = 3; i < 7; i++)
      wr(16'hF420 + 16'(i), 16'h0001);
    rd(16'hF422, 16'h0FFF);
    rd(16'hF423, 16'h0001);
    rd(16'hF424, 16'h0001);
    burst(16'hFFFF, 16'h5A3C);
    rd(16'hF427, 16'h0000);
    rd(16'hF428, 16'h0000);
    wr(16'hF425, 16'h0000);
    burst(16'h6000, 16'h0000);
    rd(16'hF428, 16'h2000);
    wr(16'hF426, 16'h0000);
    burst(16'h4000, 16'h0000);
    wr(16'hF428, 16'hFFFF);
    rd(16'hF428, 16'h2000);
    // only a rising clear bit clears
    wr(16'hF421, 16'h0001);
    burst(16'h4000, 16'h0000);
    wr(16'hF421, 16'h0001);
    rd(16'hF427, 16'h0001);
    wr(16'hF421, 16'h0000);
    wr(16'hF421, 16'h0001);
    rd(16'hF428, 16'h0000);
    wr(16'hF421, 16'h0000);
    wr(16'hF423, 16'h0000);
    burst(16'h8000, 16'hA5C3);
    rd(16'hF432, 16'hA5C3);
    chk({15'h0000, irq}, 16'h0001);
    rd(16'hF429, 16'h0007);
    wr(16'hF42A, 16'h0007);
    // The level output follows a new mask one edge after the write lands
    @(posedge ref_clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    wr(16'hF429, 16'h0007);
    rd(16'hF429, 16'h0000);
    wr(16'hF42A, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    report_and_stop;
  end
endmodule
